//--- rtl/dds_defs.vh
`ifndef DDS_DEFS_VH
`define DDS_DEFS_VH
// Clock and time base
`define DDS_CLK_HZ 100000000
`define DDS_MS_CYC (`DDS_CLK_HZ / 1000)
// Input filter times in ms
`define DDS_FILT_DEF_MS 8'h03
`define DDS_FILT_LO_MS 32'h00000003
`define DDS_FILT_HI_MS 32'h00000004
// Steps per digit, in scans
`define DDS_DIGIT_DISPLAY_DRIVER_PHASES 2'h3
// Limits
`define DDS_MAX_DIGITS 3'h5
`define DDS_MAX_VALUE 20'h0FFFF
`define DDS_MAX_DIGIT_DISPLAY_DRIVER_INST 5'h08
`define DDS_MAX_RD_INST 5'h10
`define DDS_MAX_RELAY 13'h04FD
// Register word indexes
`define DDS_REG_CTRL 3'h0
`define DDS_REG_SRC 3'h1
`define DDS_REG_DIGITS 3'h2
`define DDS_REG_TIMING 3'h3
`define DDS_REG_INST 3'h4
`define DDS_REG_RESULT 3'h5
`define DDS_REG_STATUS 3'h6
`define DDS_REG_MAP 3'h7
// Control field positions
`define DDS_CTRL_DIGIT_DISPLAY_DRIVER_GO 0
`define DDS_CTRL_RD_GO 1
`define DDS_CTRL_SRC_TC 2
`define DDS_CTRL_DIGIT_DISPLAY_DRIVER_BIN 3
`define DDS_CTRL_LATCH_POL 4
`define DDS_CTRL_DATA_POL 5
`define DDS_CTRL_RD_BIN 6
`define DDS_CTRL_ERR_CLR 7
// Reset values
`define DDS_RST_SCAN_MS 8'h0A
`define DDS_RST_DIGITS 3'h4
`endif

//--- rtl/dds_in_filter.v
`timescale 1ns/10ps
`include "dds_defs.vh"
module dds_in_filter #(
  parameter W = 4
)(
  input wire clk_sys,
  input wire rst,
  input wire [W-1:0] pin_in,
  input wire [31:0] limit,
  output reg [W-1:0] filt_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [31:0] cnt_q;

  // Value is accepted only after standing unchanged for the filter time
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      cnt_q <= 32'h00000000;
      filt_out <= {W{1'b0}};
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q != s3_q)
        cnt_q <= 32'h00000000;
      else if (cnt_q < limit)
        cnt_q <= cnt_q + 32'h00000001;
      else
        filt_out <= s3_q;
    end
  end
endmodule

//--- rtl/dds_scanner.v
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`include "dds_defs.vh"
// Summary of operation
// - Display uses four data plus per-digit latches
// - Three scans per digit while trigger held
// - Display coding selectable BCD or binary
// - Latch and data polarity each configurable
// - Timer/counter source shows its current value
// - Output map stays within relays 0 to 1277
// - Values up to 65535, five digits
// - At most eight display instances
// - Reader assembles value into destination register
// - Five-digit value above 65535 raises error
// - Over sixteen reader instances blocks execution
// - Reader coding selectable BCD or binary
// - Reader uses exactly four shared data inputs
// - One select output per digit, up to five
// - Read takes two scans times digits plus four
// - Filter time per input group selectable/fixed
module dds_scanner #(
  parameter [31:0] MS_CYCLES = `DDS_MS_CYC
)(
  input wire clk_sys,
  input wire rst,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [15:0] tc_value,
  input wire [3:0] sw_data_in,
  output reg [3:0] digit_display_driver_data,
  output reg [4:0] digit_display_driver_latch,
  output reg [4:0] sw_select,
  output reg err_ind
);
  localparam [4:0] R_IDLE = 5'h01;
  localparam [4:0] R_PREP = 5'h02;
  localparam [4:0] R_SEL = 5'h04;
  localparam [4:0] R_SAMP = 5'h08;
  localparam [4:0] R_FIN = 5'h10;

  reg [7:0] ctrl_q;
  reg [15:0] src_q;
  reg [2:0] digit_display_driver_n_q;
  reg [2:0] rd_n_q;
  reg [7:0] scan_ms_q;
  reg [7:0] filt_ms_q;
  reg [1:0] in_grp_q;
  reg [4:0] digit_display_driver_inst_q;
  reg [4:0] rd_inst_q;
  reg [10:0] first_out_q;
  reg [15:0] result_q;
  reg exec_err_q;
  reg syn_err_q;
  reg map_err_q;
  reg rd_done_q;
  reg [31:0] scan_cnt_q;
  reg scan_tick_q;
  reg digit_display_driver_go_q;
  reg rd_go_q;
  reg [2:0] digit_display_driver_idx_q;
  reg [1:0] digit_display_driver_ph_q;
  reg [15:0] digit_display_driver_val_q;
  reg [4:0] rd_st_q;
  reg rd_sub_q;
  reg [2:0] rd_dig_q;
  reg [19:0] rd_acc_q;
  wire [3:0] sw_filt;
  wire [2:0] digit_display_driver_n;
  wire [2:0] rd_n;
  wire run_en;
  wire digit_display_driver_run;
  wire rd_run;
  wire wr_en;
  wire [31:0] scan_lim;
  reg [31:0] filt_lim;
  wire [12:0] map_top;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function [2:0] clamp_n;
    input [2:0] n;
    begin
      if (n == 3'h0)
        clamp_n = 3'h1;
      else if (n > `DDS_MAX_DIGITS)
        clamp_n = `DDS_MAX_DIGITS;
      else
        clamp_n = n;
    end
  endfunction

  function [3:0] digit_of;
    input [15:0] v;
    input [2:0] k;
    input bin;
    reg [15:0] q;
    reg [15:0] r;
    begin
      q = v;
      case (k)
        3'h0: q = v;
        3'h1: q = v / 16'h000A;
        3'h2: q = v / 16'h0064;
        3'h3: q = v / 16'h03E8;
        default: q = v / 16'h2710;
      endcase
      r = q % 16'h000A;
      if (bin)
        digit_of = v[{k[1:0], 2'h0} +: 4] & {4{~k[2]}};
      else
        digit_of = r[3:0];
    end
  endfunction

  function [4:0] onehot5;
    input [2:0] k;
    begin
      onehot5 = 5'h01 << k;
    end
  endfunction

  assign digit_display_driver_n = clamp_n(digit_display_driver_n_q);
  assign rd_n = clamp_n(rd_n_q);
  // Syntax or map errors keep the whole program from running
  assign run_en = ~syn_err_q & ~map_err_q;
  assign digit_display_driver_run = ctrl_q[`DDS_CTRL_DIGIT_DISPLAY_DRIVER_GO] & run_en;
  assign rd_run = ctrl_q[`DDS_CTRL_RD_GO] & run_en;
  assign wr_en = avs_write & ~avs_waitrequest;
  // Zero preset is treated as 1 ms so the scan never stalls
  assign scan_lim = ((scan_ms_q == 8'h00) ? 32'h00000001
                     : {24'h000000, scan_ms_q}) * MS_CYCLES;
  assign map_top = {2'h0, first_out_q} + 13'h0003 + {10'h000, digit_display_driver_n};

  always @*
  begin
    case (in_grp_q)
      2'h0: filt_lim = {24'h000000, filt_ms_q} * MS_CYCLES;
      2'h1: filt_lim = `DDS_FILT_LO_MS * MS_CYCLES;
      default: filt_lim = `DDS_FILT_HI_MS * MS_CYCLES;
    endcase
  end

  dds_in_filter #(
    .W(4)
  ) u_filt (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(sw_data_in),
    .limit(filt_lim),
    .filt_out(sw_filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait cycle per access

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ctrl_q <= 8'h00;
      src_q <= 16'h0000;
      digit_display_driver_n_q <= `DDS_RST_DIGITS;
      rd_n_q <= `DDS_RST_DIGITS;
      scan_ms_q <= `DDS_RST_SCAN_MS;
      filt_ms_q <= `DDS_FILT_DEF_MS;
      in_grp_q <= 2'h0;
      digit_display_driver_inst_q <= 5'h01;
      rd_inst_q <= 5'h01;
      first_out_q <= 11'h000;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest)
      begin
        case (avs_address)
          `DDS_REG_CTRL: avs_readdata <= {24'h000000, 1'b0, ctrl_q[6:0]};
          `DDS_REG_SRC: avs_readdata <= {16'h0000, src_q};
          `DDS_REG_DIGITS:
            avs_readdata <= {25'h0000000, rd_n_q, 1'b0, digit_display_driver_n_q};
          `DDS_REG_TIMING:
            avs_readdata <= {14'h0000, in_grp_q, filt_ms_q, scan_ms_q};
          `DDS_REG_INST:
            avs_readdata <= {19'h00000, rd_inst_q, 3'h0, digit_display_driver_inst_q};
          `DDS_REG_RESULT: avs_readdata <= {16'h0000, result_q};
          `DDS_REG_STATUS:
            avs_readdata <= {26'h0000000, map_err_q, rd_done_q,
                             ~rd_st_q[0], digit_display_driver_run, syn_err_q, exec_err_q};
          default: avs_readdata <= {21'h000000, first_out_q};
        endcase
      end
      if (wr_en)
      begin
        case (avs_address)
          `DDS_REG_CTRL: ctrl_q <= {1'b0, avs_writedata[6:0]};
          `DDS_REG_SRC: src_q <= avs_writedata[15:0];
          `DDS_REG_DIGITS:
          begin
            digit_display_driver_n_q <= avs_writedata[2:0];
            rd_n_q <= avs_writedata[6:4];
          end
          `DDS_REG_TIMING:
          begin
            scan_ms_q <= avs_writedata[7:0];
            filt_ms_q <= avs_writedata[15:8];
            in_grp_q <= avs_writedata[17:16];
          end
          `DDS_REG_INST:
          begin
            digit_display_driver_inst_q <= avs_writedata[4:0];
            rd_inst_q <= avs_writedata[12:8];
          end
          `DDS_REG_MAP: first_out_q <= avs_writedata[10:0];
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan clock and program checks

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      scan_cnt_q <= 32'h00000000;
      scan_tick_q <= 1'b0;
      syn_err_q <= 1'b0;
      map_err_q <= 1'b0;
      exec_err_q <= 1'b0;
      err_ind <= 1'b0;
    end
    else
    begin
      scan_tick_q <= 1'b0;
      if (scan_cnt_q + 32'h00000001 >= scan_lim)
      begin
        scan_cnt_q <= 32'h00000000;
        scan_tick_q <= 1'b1;
      end
      else
        scan_cnt_q <= scan_cnt_q + 32'h00000001;
      syn_err_q <= (rd_inst_q > `DDS_MAX_RD_INST) |
                   (digit_display_driver_inst_q > `DDS_MAX_DIGIT_DISPLAY_DRIVER_INST);
      map_err_q <= (map_top > `DDS_MAX_RELAY);
      // Overflow set beats a same-cycle software clear
      if (rd_st_q == R_FIN && rd_sub_q && scan_tick_q &&
          rd_n == `DDS_MAX_DIGITS && rd_acc_q > `DDS_MAX_VALUE)
        exec_err_q <= 1'b1;
      else if (wr_en && avs_address == `DDS_REG_CTRL &&
               avs_writedata[`DDS_CTRL_ERR_CLR])
        exec_err_q <= 1'b0;
      err_ind <= exec_err_q | syn_err_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display driver

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      digit_display_driver_go_q <= 1'b0;
      digit_display_driver_idx_q <= 3'h0;
      digit_display_driver_ph_q <= 2'h0;
      digit_display_driver_val_q <= 16'h0000;
      digit_display_driver_data <= 4'h0;
      digit_display_driver_latch <= 5'h00;
    end
    else
    begin
      digit_display_driver_go_q <= digit_display_driver_run;
      if (digit_display_driver_run & ~digit_display_driver_go_q)
      begin
        digit_display_driver_idx_q <= 3'h0;
        digit_display_driver_ph_q <= 2'h0;
        digit_display_driver_val_q <= ctrl_q[`DDS_CTRL_SRC_TC] ? tc_value : src_q;
      end
      else if (digit_display_driver_run & scan_tick_q)
      begin
        if (digit_display_driver_ph_q == `DDS_DIGIT_DISPLAY_DRIVER_PHASES - 2'h1)
        begin
          digit_display_driver_ph_q <= 2'h0;
          if (digit_display_driver_idx_q + 3'h1 >= digit_display_driver_n)
          begin
            digit_display_driver_idx_q <= 3'h0;
            // Refresh picks up a live timer/counter each pass
            digit_display_driver_val_q <= ctrl_q[`DDS_CTRL_SRC_TC] ? tc_value : src_q;
          end
          else
            digit_display_driver_idx_q <= digit_display_driver_idx_q + 3'h1;
        end
        else
          digit_display_driver_ph_q <= digit_display_driver_ph_q + 2'h1;
      end
      digit_display_driver_data <= digit_of(digit_display_driver_val_q, digit_display_driver_idx_q,
                            ctrl_q[`DDS_CTRL_DIGIT_DISPLAY_DRIVER_BIN]) ^
                   {4{ctrl_q[`DDS_CTRL_DATA_POL]}};
      // Latch only in the middle scan so data is settled both sides
      digit_display_driver_latch <= ((digit_display_driver_run & digit_display_driver_go_q & digit_display_driver_ph_q == 2'h1)
                     ? onehot5(digit_display_driver_idx_q) : 5'h00) ^
                    {5{ctrl_q[`DDS_CTRL_LATCH_POL]}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch reader

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      rd_go_q <= 1'b0;
      rd_st_q <= R_IDLE;
      rd_sub_q <= 1'b0;
      rd_dig_q <= 3'h0;
      rd_acc_q <= 20'h00000;
      rd_done_q <= 1'b0;
      result_q <= 16'h0000;
      sw_select <= 5'h00;
    end
    else
    begin
      rd_go_q <= rd_run;
      if (~rd_run)
      begin
        rd_st_q <= R_IDLE;
        sw_select <= 5'h00;
      end
      else if (~rd_go_q)
      begin
        rd_st_q <= R_PREP;
        rd_sub_q <= 1'b0;
        rd_done_q <= 1'b0;
        rd_acc_q <= 20'h00000;
      end
      else if (scan_tick_q)
      begin
        case (rd_st_q)
          R_PREP:
          begin
            rd_sub_q <= ~rd_sub_q;
            if (rd_sub_q)
            begin
              rd_st_q <= R_SEL;
              rd_dig_q <= rd_n - 3'h1;
            end
          end
          R_SEL:
          begin
            sw_select <= onehot5(rd_dig_q);
            rd_st_q <= R_SAMP;
          end
          R_SAMP:
          begin
            rd_acc_q <= (ctrl_q[`DDS_CTRL_RD_BIN]
                         ? {rd_acc_q[15:0], 4'h0}
                         : rd_acc_q * 20'h0000A) + {16'h0000, sw_filt};
            sw_select <= 5'h00;
            if (rd_dig_q == 3'h0)
            begin
              rd_st_q <= R_FIN;
              rd_sub_q <= 1'b0;
            end
            else
            begin
              rd_dig_q <= rd_dig_q - 3'h1;
              rd_st_q <= R_SEL;
            end
          end
          R_FIN:
          begin
            rd_sub_q <= ~rd_sub_q;
            if (rd_sub_q)
            begin
              rd_st_q <= R_IDLE;
              rd_done_q <= 1'b1;
              if (!(rd_n == `DDS_MAX_DIGITS && rd_acc_q > `DDS_MAX_VALUE))
                result_q <= rd_acc_q[15:0];
            end
          end
          default: rd_st_q <= rd_st_q;
        endcase
      end
    end
  end
endmodule

//--- dv/dds_scanner_chk.sv
`timescale 1ns/10ps
module dds_scanner_chk #(
  parameter [31:0] MS_CYCLES = 32'h0000000A
)(
  input wire clk_sys,
  input wire rst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [3:0] digit_display_driver_data,
  input wire [4:0] digit_display_driver_latch,
  input wire [4:0] sw_select
);
  // Polarity is internal, so a latch counts as on if it alone differs
  wire latch_on = $onehot(digit_display_driver_latch) || $onehot(~digit_display_driver_latch);
  reg [4:0] last_sel_q;
  // Selects are split by an idle scan, so remember the last one
  always @(posedge clk_sys)
  begin
    if (rst)
      last_sel_q <= 5'h00;
    else if (sw_select != 5'h00)
      last_sel_q <= sw_select;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////
  property p_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("no bus answer");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_cause;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_cause: assert property (p_cause) else $error("stray answer");
  property p_latch_one;
    $onehot0(digit_display_driver_latch) || $onehot0(~digit_display_driver_latch);
  endproperty
  a_latch_one: assert property (p_latch_one) else $error("two latches");
  property p_latch_data;
    latch_on |-> $stable(digit_display_driver_data);
  endproperty
  a_latch_data: assert property (p_latch_data) else $error("data moved");
  property p_latch_len;
    $rose(latch_on) |=> latch_on [*8];
  endproperty
  a_latch_len: assert property (p_latch_len) else $error("short latch");
  property p_sel_one;
    $onehot0(sw_select);
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("two selects");
  property p_sel_len;
    $rose(|sw_select) |=> $stable(sw_select) [*8];
  endproperty
  a_sel_len: assert property (p_sel_len) else $error("short select");
  property p_sel_ord;
    $rose(|sw_select) && last_sel_q != 5'h00 && last_sel_q != 5'h01
      |-> sw_select == (last_sel_q >> 1);
  endproperty
  a_sel_ord: assert property (p_sel_ord) else $error("select order");
endmodule
bind dds_scanner dds_scanner_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .digit_display_driver_data(digit_display_driver_data),
  .digit_display_driver_latch(digit_display_driver_latch),
  .sw_select(sw_select)
);

//--- dv/dds_far_side.sv
`timescale 1ns/10ps
module dds_far_side (
  input wire clk_sys,
  input wire [3:0] digit_display_driver_data,
  input wire [4:0] digit_display_driver_latch,
  input wire latch_pol,
  input wire data_pol,
  input wire [4:0] sw_select,
  input wire [19:0] sw_digits,
  output reg [3:0] sw_data_in = 4'h0,
  output reg [19:0] shown = 20'h00000
);
  integer k;
  //////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    // Unselected switch lines float, so never show a stale digit
    sw_data_in <= ~sw_data_in;
    for (k = 0; k < 5; k = k + 1)
    begin
      if (digit_display_driver_latch[k] !== latch_pol)
        shown[4*k +: 4] <= digit_display_driver_data ^ {4{data_pol}};
      if (sw_select[k] === 1'b1)
        sw_data_in <= sw_digits[4*k +: 4];
    end
  end
endmodule

//--- dv/tb_digit_display_switch_scanner.sv
`timescale 1ns/10ps
module tb_digit_display_switch_scanner;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [2:0] avs_address = 3'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  reg [15:0] tc_value = 16'h0000;
  reg latch_pol = 1'b0;
  reg data_pol = 1'b0;
  reg [19:0] sw_digits = 20'h00000;
  reg [31:0] rd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [3:0] sw_data_in;
  wire [3:0] digit_display_driver_data;
  wire [4:0] digit_display_driver_latch;
  wire [4:0] sw_select;
  wire err_ind;
  wire [19:0] shown;
  integer fail_count = 0;
  integer checks_done = 0;
  integer cycles = 0;
  always #5 clk_sys = ~clk_sys;
  dds_scanner #(.MS_CYCLES(32'h0000000A)) dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .tc_value(tc_value),
    .sw_data_in(sw_data_in),
    .digit_display_driver_data(digit_display_driver_data),
    .digit_display_driver_latch(digit_display_driver_latch),
    .sw_select(sw_select),
    .err_ind(err_ind)
  );
  dds_far_side far (
    .clk_sys(clk_sys),
    .digit_display_driver_data(digit_display_driver_data),
    .digit_display_driver_latch(digit_display_driver_latch),
    .latch_pol(latch_pol),
    .data_pol(data_pol),
    .sw_select(sw_select),
    .sw_digits(sw_digits),
    .sw_data_in(sw_data_in),
    .shown(shown)
  );
  //////////////////////////////////////////////////////////////////////
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task bus(input wr, input [2:0] a, input [31:0] d);
  begin
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  end
  endtask
  task rchk(input [2:0] a, input [31:0] exp);
  begin
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp);
  end
  endtask
  task sbit(input integer b, input v);
  begin
    repeat (4) @(posedge clk_sys);
    bus(1'b0, 3'h6, 32'h00000000);
    chk({31'h0, rd[b]}, {31'h0, v});
  end
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_reset;
  begin
    chk({avs_waitrequest, digit_display_driver_data, digit_display_driver_latch, sw_select, err_ind},
      32'h00008000);
    rchk(3'h0, 32'h00000000);
    rchk(3'h2, 32'h00000044);
    rchk(3'h3, 32'h0000030A);
    rchk(3'h4, 32'h00000101);
    bus(1'b1, 3'h5, 32'h0000FFFF);
    rchk(3'h5, 32'h00000000);
    $display("reset test done");
  end
  endtask
  task t_digit_display_driver(input [31:0] ctl, input [15:0] v, input [2:0] n,
    input [19:0] exp);
    reg [19:0] m;
  begin
    latch_pol <= ctl[4];
    data_pol <= ctl[5];
    bus(1'b1, 3'h1, {16'h0000, v});
    bus(1'b1, 3'h2, {29'h00000008, n});
    bus(1'b1, 3'h0, ctl);
    sbit(2, 1'b1);
    // Three scans of 100 clocks per digit, plus slack for phase
    repeat (300 * n + 300) @(posedge clk_sys);
    m = ~(20'hFFFFF << (4 * n));
    chk({12'h000, shown & m}, {12'h000, exp});
    // Stop just after a latch pulse, so none is ever cut short
    while (digit_display_driver_latch === {5{latch_pol}})
      @(posedge clk_sys);
    while (digit_display_driver_latch !== {5{latch_pol}})
      @(posedge clk_sys);
    bus(1'b1, 3'h0, ctl & 32'h00000030);
    $display("display test done");
  end
  endtask
  task t_read(input [7:0] ctl, input [2:0] n, input [19:0] sw,
    input [15:0] exp, input err);
    integer t0;
    integer k;
  begin
    sw_digits <= sw;
    bus(1'b1, 3'h2, {25'h0000000, n, 4'h5});
    bus(1'b1, 3'h0, {24'h000000, ctl});
    t0 = cycles;
    rd = 32'h00000000;
    while (rd[4] !== 1'b1 && rd[0] !== 1'b1)
      bus(1'b0, 3'h6, 32'h00000000);
    k = cycles - t0;
    chk({31'h0, rd[3]}, 32'h00000000);
    chk(k > 200 * n + 300 && k <= 200 * n + 430, 1);
    rchk(3'h5, {16'h0000, exp});
    chk(err_ind, err);
    bus(1'b1, 3'h0, 32'h00000080);
    repeat (4) @(posedge clk_sys);
    chk(err_ind, 1'b0);
    $display("read test done");
  end
  endtask
  task t_limits;
  begin
    bus(1'b1, 3'h2, 32'h00000044);
    bus(1'b1, 3'h7, 32'h000004F6);
    sbit(5, 1'b0);
    bus(1'b1, 3'h7, 32'h000004F7);
    sbit(5, 1'b1);
    bus(1'b1, 3'h7, 32'h00000000);
    sbit(5, 1'b0);
    bus(1'b1, 3'h4, 32'h00001008);
    sbit(1, 1'b0);
    chk(err_ind, 1'b0);
    bus(1'b1, 3'h4, 32'h00001108);
    sbit(1, 1'b1);
    chk(err_ind, 1'b1);
    bus(1'b1, 3'h4, 32'h00000109);
    sbit(1, 1'b1);
    $display("limits test done");
  end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_digit_display_driver(32'h00000001, 16'h04D2, 3'h4, 20'h01234);
    tc_value <= 16'hFFFF;
    t_digit_display_driver(32'h00000005, 16'h0000, 3'h5, 20'h65535);
    t_digit_display_driver(32'h00000039, 16'hABCD, 3'h5, 20'h0ABCD);
    t_read(8'h02, 3'h4, 20'h09876, 16'h2694, 1'b0);
    t_read(8'h42, 3'h4, 20'h0BEEF, 16'hBEEF, 1'b0);
    bus(1'b1, 3'h3, 32'h0002030A);
    rchk(3'h3, 32'h0002030A);
    t_read(8'h42, 3'h1, 20'h1234F, 16'h000F, 1'b0);
    t_read(8'h02, 3'h5, 20'h65535, 16'hFFFF, 1'b0);
    t_read(8'h02, 3'h5, 20'h70000, 16'hFFFF, 1'b1);
    t_limits;
    stop_test;
  end
endmodule
